// ==== sdc_pkg.sv ====
// package: command encodings, timing constants and carrier structs for the sdram host controller
package sdc_pkg;

  // pin command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_DESELECT = 4'h8;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_BURST_TERM = 4'h6;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_MODE_LOAD = 4'h0;

  // field positions and widths
  localparam int ADDR_W = 13;
  localparam int ROW_W = 12;
  localparam int COL_W = 11;
  localparam int DATA_W = 16;
  localparam int MASK_W = 2;
  localparam int AP_BIT = 10;
  localparam int MODE_HIGH_BIT = 12;
  localparam int NUM_BANKS = 4;
  localparam int FIFO_DEPTH = 4;

  // clock and timing, times in ns, refresh intervals in ps, exit minimum in clocks
  localparam int CLK_PERIOD_NS = 10;
  localparam int MODE_LOAD_WAIT_NS = 20;
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int ROW_ACTIVE_MIN_NS = 44;
  localparam int REFRESH_CYCLE_NS = 66;
  localparam int SELF_REFRESH_EXIT_WAIT_NS = 75;
  localparam int ACT_TO_RW_NS = 20;
  localparam int SELF_REFRESH_EXIT_MIN_CLK = 2;
  localparam int REFRESH_INTERVAL_STD_PS = 15625000;
  localparam int REFRESH_INTERVAL_AUTO_PS = 3906000;
  localparam int CAS_LATENCY = 2;
  localparam int BURST_LEN = 1;

  // least times round up, longest times round down
  localparam int MODE_LOAD_WAIT_CYC = (MODE_LOAD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_ACTIVE_CYC = (ROW_ACTIVE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = (REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACT_TO_RW_CYC = (ACT_TO_RW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int XSR_RAW = (SELF_REFRESH_EXIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_EXIT_CYC =
    (XSR_RAW > SELF_REFRESH_EXIT_MIN_CLK) ? XSR_RAW : SELF_REFRESH_EXIT_MIN_CLK;
  localparam int REFRESH_STD_CYC = REFRESH_INTERVAL_STD_PS / (CLK_PERIOD_NS * 1000);
  localparam int REFRESH_AUTO_CYC = REFRESH_INTERVAL_AUTO_PS / (CLK_PERIOD_NS * 1000);
  localparam int WAIT_W = 12;

  typedef enum logic [2:0] {
    SDC_OP_READ = 3'h0,
    SDC_OP_WRITE = 3'h1,
    SDC_OP_MODE_LOAD = 3'h2,
    SDC_OP_PRECHARGE_ALL = 3'h3,
    SDC_OP_BURST_TERM = 3'h4
  } sdc_op_e;

  typedef struct packed {
    sdc_op_e op;
    logic [1:0] bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic auto_pre;
    logic [DATA_W-1:0] wdata;
    logic [MASK_W-1:0] mask;
  } sdc_req_s;

  typedef struct packed {
    logic [3:0] cmd;
    logic [1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] mask;
    logic cke;
  } sdc_pins_s;

endpackage : sdc_pkg

// ==== sdc_fifo.sv ====
// parameterised valid/ready fifo held in flip-flops
`timescale 1ns/1ns
module sdc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end
endmodule : sdc_fifo

// ==== sdc_ctrl.sv ====
// host-side sdram command controller: bank tracking, timing waits and refresh scheduling
// Contract
// - command codes come from four strobe pins
// - refresh code: clock gate selects auto/self
// - mode load uses A0-A11, A12 low
// - mode load only when idle, then wait
// - precharge before opening another row
// - wait precharge period, then activate first
// - after auto precharge wait precharge period
// - precharge all before auto refresh
// - refresh every 15.625us standard grade
// - automotive grade refresh every 3.906us
// - self refresh holds clock gate low
// - stay in self refresh row-active time
// - stable clock, raise gate, nops for wait
// - resume refreshes at 15.625us after exit; code refreshes as soon as the exit wait ends
`timescale 1ns/1ns
module sdc_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // user requests
  input wire logic req_valid,
  output logic req_ready,
  input wire sdc_pkg::sdc_req_s req_data,
  // read return
  output logic rd_valid,
  output logic [sdc_pkg::DATA_W-1:0] rd_data,
  // control
  input wire logic auto_grade,
  input wire logic self_refresh_req,
  output logic in_self_refresh,
  output logic init_done,
  // sdram pins
  output logic sd_cs_n,
  output logic sd_ras_n,
  output logic sd_cas_n,
  output logic sd_we_n,
  output logic sd_cke,
  output logic [1:0] sd_bank,
  output logic [sdc_pkg::ADDR_W-1:0] sd_addr,
  output logic [sdc_pkg::MASK_W-1:0] sd_dqm,
  input wire logic [sdc_pkg::DATA_W-1:0] sd_dq_in,
  output logic [sdc_pkg::DATA_W-1:0] sd_dq_out,
  output logic sd_dq_oe
);
  typedef enum logic [2:0] {
    SDC_ST_INIT = 3'b000,
    SDC_ST_IDLE = 3'b001,
    SDC_ST_ACCESS = 3'b011,
    SDC_ST_WAIT = 3'b010,
    SDC_ST_REF_PRE = 3'b110,
    SDC_ST_SELF = 3'b111,
    SDC_ST_SELF_EXIT = 3'b101
  } sdc_state_e;

  localparam int RD_PIPE = sdc_pkg::CAS_LATENCY + 1;

  function automatic logic [sdc_pkg::WAIT_W-1:0] cyc(input int n);
    cyc = sdc_pkg::WAIT_W'(n);
  endfunction : cyc

  sdc_state_e state_r;
  sdc_pkg::sdc_pins_s pins_r;
  logic [sdc_pkg::WAIT_W-1:0] wait_r;
  logic [sdc_pkg::WAIT_W-1:0] ref_cnt_r;
  logic ref_due_r;
  logic [sdc_pkg::NUM_BANKS-1:0] bank_open_r;
  logic [sdc_pkg::ROW_W-1:0] open_row_r [sdc_pkg::NUM_BANKS];
  logic [1:0] mode_step_r;
  logic [RD_PIPE-1:0] rd_pipe_r;
  logic rd_valid_r;
  logic [sdc_pkg::DATA_W-1:0] rd_data_r;
  logic [sdc_pkg::DATA_W-1:0] dq_out_r;
  logic dq_oe_r;
  logic self_r;
  logic init_done_r;

  // request queue
  logic q_valid;
  logic q_pop;
  sdc_pkg::sdc_req_s q_req;

  sdc_fifo #(
    .WIDTH($bits(sdc_pkg::sdc_req_s)),
    .DEPTH(sdc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req_data),
    .out_valid(q_valid),
    .out_ready(q_pop),
    .out_data(q_req)
  );

  logic wait_done;
  logic row_hit;
  logic row_miss;
  logic is_rw;
  assign wait_done = (wait_r == '0);
  assign is_rw = (q_req.op == sdc_pkg::SDC_OP_READ) || (q_req.op == sdc_pkg::SDC_OP_WRITE);
  assign row_hit = bank_open_r[q_req.bank] && (open_row_r[q_req.bank] == q_req.row);
  assign row_miss = bank_open_r[q_req.bank] && (open_row_r[q_req.bank] != q_req.row);

  // refresh interval timer, spacing per temperature grade
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_r <= '0;
      ref_due_r <= 1'b0;
    end else if (state_r == SDC_ST_SELF) begin
      ref_cnt_r <= '0;
      ref_due_r <= 1'b1; // first refresh right after exit
    end else if (pins_r.cmd == sdc_pkg::CMD_REFRESH && pins_r.cke) begin
      ref_cnt_r <= '0;
      ref_due_r <= 1'b0;
    end else if (ref_cnt_r >= (auto_grade ? cyc(sdc_pkg::REFRESH_AUTO_CYC - 1)
                                          : cyc(sdc_pkg::REFRESH_STD_CYC - 1))) begin
      ref_due_r <= 1'b1;
    end else begin
      ref_cnt_r <= ref_cnt_r + 1'b1;
    end
  end

  // command sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= SDC_ST_INIT;
      pins_r <= '{cmd: sdc_pkg::CMD_NOP, bank: 2'h0, addr: '0, mask: '1, cke: 1'b1};
      wait_r <= cyc(sdc_pkg::PRECHARGE_CYC);
      bank_open_r <= '0;
      mode_step_r <= 2'h0;
      self_r <= 1'b0;
      dq_out_r <= '0;
      dq_oe_r <= 1'b0;
      rd_pipe_r <= '0;
    end else begin
      pins_r.cmd <= sdc_pkg::CMD_NOP; // default keeps the device idle
      pins_r.mask <= '0;
      dq_oe_r <= 1'b0;
      rd_pipe_r <= {rd_pipe_r[RD_PIPE-2:0], 1'b0};
      if (!wait_done) begin
        wait_r <= wait_r - 1'b1;
      end
      case (state_r)
        SDC_ST_INIT: begin
          if (wait_done) begin
            case (mode_step_r)
              2'h0: begin
                pins_r.cmd <= sdc_pkg::CMD_PRECHARGE;
                pins_r.addr <= sdc_pkg::ADDR_W'(1) << sdc_pkg::AP_BIT;
                wait_r <= cyc(sdc_pkg::PRECHARGE_CYC - 1);
              end
              2'h1, 2'h2: begin
                pins_r.cmd <= {3'h0, 1'b1}; // auto refresh code
                wait_r <= cyc(sdc_pkg::REFRESH_CYC - 1);
              end
              default: begin
                pins_r.cmd <= sdc_pkg::CMD_MODE_LOAD;
                // burst 1, sequential, latency field, A12 driven low
                pins_r.addr <= sdc_pkg::ADDR_W'(sdc_pkg::CAS_LATENCY << 4);
                pins_r.addr[sdc_pkg::MODE_HIGH_BIT] <= 1'b0;
                wait_r <= cyc(sdc_pkg::MODE_LOAD_WAIT_CYC - 1);
                state_r <= SDC_ST_WAIT;
              end
            endcase
            mode_step_r <= mode_step_r + 1'b1;
          end
        end
        SDC_ST_IDLE: begin
          if (wait_done) begin
            if (ref_due_r || self_refresh_req) begin
              if (bank_open_r != '0) begin
                pins_r.cmd <= sdc_pkg::CMD_PRECHARGE;
                pins_r.addr <= sdc_pkg::ADDR_W'(1) << sdc_pkg::AP_BIT;
                bank_open_r <= '0;
                wait_r <= cyc(sdc_pkg::PRECHARGE_CYC - 1);
              end else begin
                pins_r.cmd <= sdc_pkg::CMD_REFRESH;
                if (self_refresh_req && !ref_due_r) begin
                  pins_r.cke <= 1'b0;
                  self_r <= 1'b1;
                  wait_r <= cyc(sdc_pkg::ROW_ACTIVE_CYC - 1);
                  state_r <= SDC_ST_SELF;
                end else begin
                  wait_r <= cyc(sdc_pkg::REFRESH_CYC - 1);
                end
              end
            end else if (q_valid) begin
              state_r <= SDC_ST_ACCESS;
            end
          end
        end
        SDC_ST_ACCESS: begin
          if (q_req.op == sdc_pkg::SDC_OP_BURST_TERM) begin
            pins_r.cmd <= sdc_pkg::CMD_BURST_TERM;
            state_r <= SDC_ST_IDLE;
          end else if (q_req.op == sdc_pkg::SDC_OP_PRECHARGE_ALL ||
                       (q_req.op == sdc_pkg::SDC_OP_MODE_LOAD && bank_open_r != '0)) begin
            pins_r.cmd <= sdc_pkg::CMD_PRECHARGE;
            pins_r.addr <= sdc_pkg::ADDR_W'(1) << sdc_pkg::AP_BIT;
            bank_open_r <= '0;
            wait_r <= cyc(sdc_pkg::PRECHARGE_CYC - 1);
            state_r <= (q_req.op == sdc_pkg::SDC_OP_PRECHARGE_ALL) ? SDC_ST_WAIT : SDC_ST_REF_PRE;
          end else if (q_req.op == sdc_pkg::SDC_OP_MODE_LOAD) begin
            pins_r.cmd <= sdc_pkg::CMD_MODE_LOAD; // all banks idle here
            pins_r.addr <= {1'b0, q_req.row};
            wait_r <= cyc(sdc_pkg::MODE_LOAD_WAIT_CYC - 1);
            state_r <= SDC_ST_WAIT;
          end else if (row_miss) begin
            pins_r.cmd <= sdc_pkg::CMD_PRECHARGE; // close old row first
            pins_r.bank <= q_req.bank;
            pins_r.addr <= '0;
            bank_open_r[q_req.bank] <= 1'b0;
            wait_r <= cyc(sdc_pkg::PRECHARGE_CYC - 1);
            state_r <= SDC_ST_REF_PRE;
          end else if (!row_hit) begin
            pins_r.cmd <= sdc_pkg::CMD_ACTIVE;
            pins_r.bank <= q_req.bank;
            pins_r.addr <= {1'b0, q_req.row};
            bank_open_r[q_req.bank] <= 1'b1;
            open_row_r[q_req.bank] <= q_req.row;
            wait_r <= cyc(sdc_pkg::ROW_ACTIVE_CYC - 1);
            state_r <= SDC_ST_REF_PRE;
          end else if (is_rw) begin
            pins_r.cmd <= (q_req.op == sdc_pkg::SDC_OP_READ) ? sdc_pkg::CMD_READ
                                                              : sdc_pkg::CMD_WRITE;
            pins_r.bank <= q_req.bank;
            pins_r.addr <= {2'b00, q_req.col};
            pins_r.addr[sdc_pkg::AP_BIT] <= q_req.auto_pre; // per command
            pins_r.mask <= q_req.mask; // write mask with data, read mask two clocks on
            if (q_req.op == sdc_pkg::SDC_OP_WRITE) begin
              dq_out_r <= q_req.wdata;
              dq_oe_r <= 1'b1;
            end else begin
              rd_pipe_r[0] <= 1'b1;
            end
            if (q_req.auto_pre) begin
              bank_open_r[q_req.bank] <= 1'b0;
              wait_r <= cyc(sdc_pkg::PRECHARGE_CYC + RD_PIPE);
            end else begin
              wait_r <= cyc(RD_PIPE);
            end
            state_r <= SDC_ST_WAIT;
          end else begin
            state_r <= SDC_ST_IDLE;
          end
        end
        SDC_ST_REF_PRE: begin
          if (wait_done) begin
            state_r <= SDC_ST_ACCESS; // retry the same request after the wait
          end
        end
        SDC_ST_WAIT: begin
          if (wait_done) begin
            state_r <= SDC_ST_IDLE;
          end
        end
        SDC_ST_SELF: begin
          pins_r.cke <= 1'b0;
          if (wait_done && !self_refresh_req) begin
            pins_r.cke <= 1'b1; // clock has run throughout
            wait_r <= cyc(sdc_pkg::SELF_EXIT_CYC - 1);
            state_r <= SDC_ST_SELF_EXIT;
          end
        end
        SDC_ST_SELF_EXIT: begin
          if (wait_done) begin // nops until exit wait is over
            self_r <= 1'b0;
            state_r <= SDC_ST_IDLE;
          end
        end
        default: begin
          state_r <= SDC_ST_IDLE;
        end
      endcase
    end
  end

  // a request leaves the queue in the cycle its command is issued
  assign q_pop = (state_r == SDC_ST_ACCESS) && q_valid &&
                 ((q_req.op == sdc_pkg::SDC_OP_BURST_TERM) ||
                  (q_req.op == sdc_pkg::SDC_OP_PRECHARGE_ALL) ||
                  (q_req.op == sdc_pkg::SDC_OP_MODE_LOAD && bank_open_r == '0) ||
                  (is_rw && row_hit));

  // status flag kept in a flip-flop so the port is glitch free
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_done_r <= 1'b0;
    end else begin
      init_done_r <= (state_r != SDC_ST_INIT);
    end
  end

  // read data captured after the latency, one cycle of pin registers added
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      rd_valid_r <= rd_pipe_r[RD_PIPE-1];
      if (rd_pipe_r[RD_PIPE-1]) begin
        rd_data_r <= sd_dq_in;
      end
    end
  end

  assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = pins_r.cmd;
  assign sd_cke = pins_r.cke;
  assign sd_bank = pins_r.bank;
  assign sd_addr = pins_r.addr;
  assign sd_dqm = pins_r.mask;
  assign sd_dq_out = dq_out_r;
  assign sd_dq_oe = dq_oe_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign in_self_refresh = self_r;
  assign init_done = init_done_r;
endmodule : sdc_ctrl

// ==== sdc_mem_model.sv ====
// behavioural sdram device: four banks, one-word bursts, byte masks
`timescale 1ns/1ns
module sdc_mem_model (
  // clock and command pins
  input wire logic ref_clk,
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n,
  input wire logic sd_cke,
  input wire logic [1:0] sd_bank,
  input wire logic [sdc_pkg::ADDR_W-1:0] sd_addr,
  // data pins and count of rule violations
  input wire logic [sdc_pkg::MASK_W-1:0] sd_dqm,
  input wire logic [sdc_pkg::DATA_W-1:0] sd_dq_out,
  input wire logic sd_dq_oe,
  output logic [sdc_pkg::DATA_W-1:0] sd_dq_in,
  output int viol
);
  logic [15:0] mem [int];
  logic [11:0] row_r [4];
  logic [3:0] open_r = 4'h0;
  logic self_r = 1'b0;
  logic rd1_r = 1'b0;
  logic rd2_r = 1'b0;
  logic [15:0] d1_r, d2_r, old;
  logic [15:0] pat_r = 16'h5a5a;
  logic [1:0] m1_r, m2_r;
  logic [3:0] cmd;
  int key;
  assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  assign key = int'({sd_bank, row_r[sd_bank], sd_addr[8:0]});
  // released lanes toggle each cycle so a floating bus never looks stable
  assign sd_dq_in = rd2_r ? {m2_r[1] ? pat_r[15:8] : d2_r[15:8],
                             m2_r[0] ? pat_r[7:0] : d2_r[7:0]} : pat_r;
  initial viol = 0;
  always @(posedge ref_clk) begin
    pat_r <= ~pat_r;
    rd1_r <= 1'b0;
    rd2_r <= rd1_r;
    d2_r <= d1_r;
    m2_r <= m1_r;
    old = mem.exists(key) ? mem[key] : 16'h0000;
    if (self_r) begin
      // refresh runs on its own clock here; every pin but the clock gate is ignored
      self_r <= !sd_cke;
    end else if (!sd_cs_n) begin
      case (cmd)
        sdc_pkg::CMD_ACTIVE: begin
          if (open_r[sd_bank]) viol++;
          open_r[sd_bank] <= 1'b1;
          row_r[sd_bank] <= sd_addr[11:0];
        end
        sdc_pkg::CMD_READ, sdc_pkg::CMD_WRITE: begin
          if (!open_r[sd_bank]) viol++;
          if (sd_addr[10]) open_r[sd_bank] <= 1'b0;
          rd1_r <= cmd == sdc_pkg::CMD_READ;
          d1_r <= old;
          m1_r <= sd_dqm;
          if (cmd == sdc_pkg::CMD_WRITE) begin
            if (!sd_dq_oe) viol++;
            mem[key] = {sd_dqm[1] ? old[15:8] : sd_dq_out[15:8],
                        sd_dqm[0] ? old[7:0] : sd_dq_out[7:0]};
          end
        end
        sdc_pkg::CMD_PRECHARGE: begin
          if (sd_addr[10]) open_r <= 4'h0;
          else open_r[sd_bank] <= 1'b0;
        end
        sdc_pkg::CMD_REFRESH: begin
          if (open_r != 4'h0) viol++;
          self_r <= !sd_cke;
        end
        sdc_pkg::CMD_MODE_LOAD: if (open_r != 4'h0 || sd_addr[12]) viol++;
        // a one-word burst is already over, so terminate leaves the row open
        default: ;
      endcase
    end
  end
endmodule : sdc_mem_model

// ==== sdc_ctrl_chk.sv ====
// pin-level assertions for the sdram host controller
`timescale 1ns/1ns
module sdc_ctrl_chk (
  // clock, reset and status
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic auto_grade,
  input wire logic rd_valid,
  // sdram pins
  input wire logic sd_cs_n,
  input wire logic sd_ras_n,
  input wire logic sd_cas_n,
  input wire logic sd_we_n,
  input wire logic sd_cke,
  input wire logic [1:0] sd_bank,
  input wire logic [sdc_pkg::ADDR_W-1:0] sd_addr,
  input wire logic sd_dq_oe
);
  // slack lets a request already under way finish before a due refresh
  localparam int SLACK = 40;
  logic [3:0] cmd;
  logic [3:0] open_r;
  logic [3:0] shut;
  logic nop;
  int pre_r [4];
  int ref_r;
  assign cmd = {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n};
  assign nop = sd_cs_n || cmd == sdc_pkg::CMD_NOP;
  always_comb begin
    shut = 4'h0;
    if (cmd == sdc_pkg::CMD_PRECHARGE) shut = sd_addr[10] ? 4'hf : 4'h1 << sd_bank;
    if (cmd[3:1] == 3'h2 && sd_addr[10]) shut = 4'h1 << sd_bank;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      open_r <= 4'h0;
      ref_r <= 0;
    end else begin
      open_r <= (cmd == sdc_pkg::CMD_ACTIVE) ? open_r | 4'h1 << sd_bank : open_r & ~shut;
      ref_r <= (!sd_cke || cmd == sdc_pkg::CMD_REFRESH) ? 0 : ref_r + 1;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!arst_n) pre_r[i] <= 9;
      else pre_r[i] <= shut[i] ? 0 : (pre_r[i] < 9 ? pre_r[i] + 1 : 9);
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_mode_ok; cmd == sdc_pkg::CMD_MODE_LOAD |-> !sd_addr[12] && open_r == 4'h0; endproperty
  a_mode_ok: assert property (p_mode_ok) else $error("bad mode load");
  property p_mode_wait; cmd == sdc_pkg::CMD_MODE_LOAD |=> nop; endproperty
  a_mode_wait: assert property (p_mode_wait) else $error("mode load wait short");
  property p_act_closed; cmd == sdc_pkg::CMD_ACTIVE |-> !open_r[sd_bank]; endproperty
  a_act_closed: assert property (p_act_closed) else $error("activate on open bank");
  property p_act_wait;
    cmd == sdc_pkg::CMD_ACTIVE |-> pre_r[sd_bank] >= sdc_pkg::PRECHARGE_CYC - 1;
  endproperty
  a_act_wait: assert property (p_act_wait) else $error("activate too soon");
  property p_rw_open; cmd[3:1] == 3'h2 |-> open_r[sd_bank]; endproperty
  a_rw_open: assert property (p_rw_open) else $error("access to idle bank");
  property p_wr_oe; cmd == sdc_pkg::CMD_WRITE |-> sd_dq_oe; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write without data drive");
  property p_ref_idle; cmd == sdc_pkg::CMD_REFRESH |-> open_r == 4'h0; endproperty
  a_ref_idle: assert property (p_ref_idle) else $error("refresh with open bank");
  property p_ref_gap;
    ref_r <= (auto_grade ? sdc_pkg::REFRESH_AUTO_CYC : sdc_pkg::REFRESH_STD_CYC) + SLACK;
  endproperty
  a_ref_gap: assert property (p_ref_gap) else $error("refresh overdue");
  property p_sr_hold; cmd == sdc_pkg::CMD_REFRESH && !sd_cke |=> !sd_cke [*5]; endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("self refresh left early");
  property p_sr_exit; $rose(sd_cke) |-> nop [*8]; endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("command during exit wait");
  property p_sr_resume; $rose(sd_cke) |-> ##[8:60] cmd == sdc_pkg::CMD_REFRESH; endproperty
  a_sr_resume: assert property (p_sr_resume) else $error("no refresh after exit");
  // two latency clocks and the capture register follow the command on the pins
  property p_rd_lat; cmd == sdc_pkg::CMD_READ |-> ##3 rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  c_sr: cover property (cmd == sdc_pkg::CMD_REFRESH && !sd_cke);
  c_ap: cover property (cmd == sdc_pkg::CMD_READ && sd_addr[10]);
  c_mode: cover property (cmd == sdc_pkg::CMD_MODE_LOAD);
endmodule : sdc_ctrl_chk

bind sdc_ctrl sdc_ctrl_chk sdc_ctrl_chk_inst (.ref_clk(ref_clk), .arst_n(arst_n),
  .auto_grade(auto_grade), .rd_valid(rd_valid), .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n),
  .sd_cas_n(sd_cas_n), .sd_we_n(sd_we_n), .sd_cke(sd_cke), .sd_bank(sd_bank),
  .sd_addr(sd_addr), .sd_dq_oe(sd_dq_oe));

// ==== tb_sdc_ctrl.sv ====
// self-checking bench: random traffic, refresh and self refresh against a device model
`timescale 1ns/1ns
module tb_sdc_ctrl;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic auto_grade = 1'b1;
  logic self_refresh_req = 1'b0;
  sdc_pkg::sdc_req_s req_data = '0;
  logic req_ready, rd_valid, in_self_refresh, init_done, cs_n, ras_n, cas_n, we_n, cke, dq_oe;
  logic [1:0] bank, dqm;
  logic [sdc_pkg::ADDR_W-1:0] addr;
  logic [15:0] rd_data, dq_in, dq_out, old;
  logic [15:0] mem [int];
  logic [15:0] exp_q [$];
  int errors = 0, num_checks = 0, seed = 20, refs = 0, stalls = 0, viol;
  initial forever #5 ref_clk = ~ref_clk;
  sdc_ctrl sdc_ctrl_inst (.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_data(req_data), .rd_valid(rd_valid), .rd_data(rd_data),
    .auto_grade(auto_grade), .self_refresh_req(self_refresh_req),
    .in_self_refresh(in_self_refresh), .init_done(init_done), .sd_cs_n(cs_n),
    .sd_ras_n(ras_n), .sd_cas_n(cas_n), .sd_we_n(we_n), .sd_cke(cke), .sd_bank(bank),
    .sd_addr(addr), .sd_dqm(dqm), .sd_dq_in(dq_in), .sd_dq_out(dq_out), .sd_dq_oe(dq_oe));
  sdc_mem_model sdc_mem_model_inst (.ref_clk(ref_clk), .sd_cs_n(cs_n), .sd_ras_n(ras_n),
    .sd_cas_n(cas_n), .sd_we_n(we_n), .sd_cke(cke), .sd_bank(bank), .sd_addr(addr),
    .sd_dqm(dqm), .sd_dq_out(dq_out), .sd_dq_oe(dq_oe), .sd_dq_in(dq_in), .viol(viol));
  always @(posedge ref_clk) if (cke && {cs_n, ras_n, cas_n, we_n} == sdc_pkg::CMD_REFRESH) refs++;
  always @(negedge ref_clk) begin
    if (rd_valid === 1'b1) begin
      check(exp_q.size() > 0, 1);
      if (exp_q.size() > 0) check(rd_data, exp_q.pop_front());
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task done(input string s);
    $display("test %0s finished, %0d mismatches", s, errors);
  endtask : done
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    if (s !== v) begin
      check(s, v);
      final_report();
    end
  endtask : wait_sig
  task push(input sdc_pkg::sdc_op_e op, input int b, r, c, input logic ap,
            input logic [15:0] wd, input logic [1:0] m);
    int k;
    k = {b[1:0], r[11:0], c[8:0]};
    old = mem.exists(k) ? mem[k] : 16'h0000;
    if (op == sdc_pkg::SDC_OP_WRITE) mem[k] = {m[1] ? old[15:8] : wd[15:8], m[0] ? old[7:0] : wd[7:0]};
    if (op == sdc_pkg::SDC_OP_READ) exp_q.push_back(old);
    req_data = '{op, b[1:0], r[11:0], c[10:0], ap, wd, m};
    req_valid = 1'b1;
    if (req_ready !== 1'b1) stalls++;
    wait_sig(req_ready, 1'b1, 300);
    @(negedge ref_clk);
  endtask : push
  // few rows and many columns so hits, misses and auto precharge all occur
  task traffic(input int n);
    int b, r, c, v;
    for (int i = 0; i < n; i++) begin
      b = $random(seed) & 3;
      r = $random(seed) & 3;
      c = $random(seed) & 511;
      v = $random(seed);
      push(sdc_pkg::SDC_OP_WRITE, b, r, c, v[16], v[15:0], v[18:17]);
      push(sdc_pkg::SDC_OP_READ, b, r, c, v[19], 16'h0000, 2'h0);
      if (i % 4 == 3) push(sdc_pkg::sdc_op_e'(2 + i / 4 % 3), 0, 32, 0, 1'b0, 16'h0000, 2'h0);
    end
    req_valid = 1'b0;
  endtask : traffic
  task drain;
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    check(exp_q.size(), 0);
    if (exp_q.size() > 0) final_report();
  endtask : drain
  task do_reset(input logic grade);
    arst_n = 1'b0;
    auto_grade = grade;
    repeat (4) @(negedge ref_clk);
    check({cs_n, ras_n, cas_n, we_n, cke, dqm, dq_oe, rd_valid}, {sdc_pkg::CMD_NOP, 5'h1c});
    arst_n = 1'b1;
    wait_sig(init_done, 1'b1, 200);
  endtask : do_reset
  initial begin
    do_reset(1'b1);
    done("reset");
    traffic(24);
    drain();
    check(stalls > 0, 1);
    done("traffic");
    refs = 0;
    repeat (2000) @(negedge ref_clk);
    check(refs >= 2000 / sdc_pkg::REFRESH_AUTO_CYC - 1, 1);
    done("refresh");
    self_refresh_req = 1'b1;
    wait_sig(in_self_refresh, 1'b1, 2000);
    repeat (50) @(negedge ref_clk);
    check(cke, 1'b0);
    self_refresh_req = 1'b0;
    wait_sig(in_self_refresh, 1'b0, 300);
    refs = 0;
    repeat (60) @(negedge ref_clk);
    check({cke, refs > 0}, 2'h3);
    traffic(4);
    drain();
    done("self refresh");
    do_reset(1'b0);
    traffic(12);
    drain();
    refs = 0;
    repeat (3200) @(negedge ref_clk);
    check(refs >= 3200 / sdc_pkg::REFRESH_STD_CYC - 1, 1);
    check(viol, 0);
    done("second reset");
    final_report();
  end
endmodule : tb_sdc_ctrl
